// file: smbc_controller.sv
// register bank and access sequencer of the static memory bus controller
// assumes the processor holds a request until cpuReady and drives privMode
`timescale 1ns/1ns

// Overview of operation
// [RL1] registers 16 bits, word aligned, half-word writes
// [RL2] reads in any mode, writes privileged only
// [RL3] register data on low data lanes
// [RL4] write_strobe_delay field delays write strobe 0-3
// [RL5] trailing field sets waits after accesses
// [RL6] active field inserts 0-15 wait states
// [RL7] read-only bit shows processor byte order
// [RL8] width field selects 8, 16, 32 bits
// [RL9] override clear forces one trailing write wait
// [RL10] memory buffer releases processor on capture
// [RL11] busy buffered write stalls next request
// [RL12] peripheral buffer gives same write capture
// [RL13] placement bits mark peripherals external
// [RL14] guard bits restrict peripherals to privilege
// [RL15] all fields reset to zero
// [RL16] unprivileged or wrong-size writes are ignored
module smbc_controller (
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire logic                regSel,
	input  wire logic                regWrite,
	input  wire logic [1:0]          regSize,
	input  wire logic [39:0]         regAddr,
	input  wire logic [31:0]         regWdata,
	input  wire logic                privMode,
	output logic [31:0]              regRdata,
	input  wire logic                endianPin,
	input  wire logic                cpuReqValid,
	input  wire smbc_pkg::smbc_req_type cpuReq,
	input  wire logic                cpuPriv,
	output logic                     cpuReady,
	output logic                     cpuFault,
	output logic [31:0]              cpuRdata,
	input  wire logic [31:0]         extRdata,
	output logic                     extSel,
	output logic                     extWriteStrobe,
	output logic                     extReadStrobe,
	output logic [31:0]              extAddr,
	output logic [31:0]              extWdata,
	output logic [1:0]               extWidth,
	output logic                     periphExternal,
	output logic                     intPeriphStrobe
);

	logic [15:0]                 timing_q;
	logic [15:0]                 wbufCtrl_q;
	logic [15:0]                 pbufCtrl_q;
	logic [15:0]                 placement_q;
	logic [15:0]                 guard_q;
	logic [31:0]                 regRdata_q;
	logic                        endianMeta_q;
	logic                        endianSync_q;
	smbc_pkg::smbc_state_type    state_q;
	smbc_pkg::smbc_state_type    state_d;
	logic [3:0]                  cnt_q;
	logic [3:0]                  cnt_d;
	smbc_pkg::smbc_req_type      req_q;
	logic                        owner_q;
	logic [31:0]                 cpuRdata_q;
	logic                        regWrOk;
	logic                        idleReq;
	logic                        faultReq;
	logic                        internalReq;
	logic                        bufferedReq;
	logic                        startExt;
	logic                        finish;
	logic [1:0]                  leadF;
	logic [3:0]                  activeF;
	logic [3:0]                  trailNow;

	// trailing count, at least one after writes unless overridden
	function automatic logic [3:0] trailCount(input logic wr, input logic [2:0] tr,
			input logic ovr);
		if (wr && !ovr && tr == 3'h0) begin
			trailCount = 4'h1; // RL9
		end else begin
			trailCount = {1'b0, tr}; // RL5
		end
	endfunction : trailCount

	// byte order strap crosses in through two flops
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			endianMeta_q <= 1'b0;
			endianSync_q <= 1'b0;
		end else begin
			endianMeta_q <= endianPin;
			endianSync_q <= endianMeta_q;
		end
	end

	// only privileged half-word writes reach the registers
	assign regWrOk = regSel && regWrite && privMode && regSize == smbc_pkg::SIZE_HALF; // RL2 RL16

	// control register bank
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			timing_q    <= smbc_pkg::REG_RESET; // RL15
			wbufCtrl_q  <= smbc_pkg::REG_RESET;
			pbufCtrl_q  <= smbc_pkg::REG_RESET;
			placement_q <= smbc_pkg::REG_RESET;
			guard_q     <= smbc_pkg::REG_RESET;
		end else if (regWrOk) begin
			unique case (regAddr) // RL1
				smbc_pkg::OFF_TIMING:
					timing_q <= regWdata[15:0] & smbc_pkg::TIMING_WMASK; // RL3
				smbc_pkg::OFF_WBUF_CTRL:
					wbufCtrl_q <= regWdata[15:0] & smbc_pkg::WBUF_WMASK;
				smbc_pkg::OFF_PBUF_CTRL:
					pbufCtrl_q <= regWdata[15:0] & smbc_pkg::PBUF_WMASK; // RL12
				smbc_pkg::OFF_PLACEMENT:
					placement_q <= regWdata[15:0]; // RL13
				smbc_pkg::OFF_PRIV_GUARD:
					guard_q <= regWdata[15:0]; // RL14
				default: begin
				end
			endcase
		end
	end

	// read data on the low lanes, one cycle after the select
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			regRdata_q <= 32'h0000_0000;
		end else if (regSel && !regWrite) begin
			unique case (regAddr)
				smbc_pkg::OFF_TIMING: begin
					regRdata_q <= {smbc_pkg::READ_PAD, timing_q}; // RL3
					regRdata_q[smbc_pkg::ENDIAN_BIT] <= endianSync_q; // RL7
				end
				smbc_pkg::OFF_WBUF_CTRL:
					regRdata_q <= {smbc_pkg::READ_PAD, wbufCtrl_q};
				smbc_pkg::OFF_PBUF_CTRL:
					regRdata_q <= {smbc_pkg::READ_PAD, pbufCtrl_q};
				smbc_pkg::OFF_PLACEMENT:
					regRdata_q <= {smbc_pkg::READ_PAD, placement_q};
				smbc_pkg::OFF_PRIV_GUARD:
					regRdata_q <= {smbc_pkg::READ_PAD, guard_q};
				default:
					regRdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign regRdata = regRdata_q;

	// timing fields
	assign leadF    = timing_q[smbc_pkg::WRITE_STROBE_DELAY_HI:smbc_pkg::WRITE_STROBE_DELAY_LO];
	assign activeF  = timing_q[smbc_pkg::ACTIVE_HI:smbc_pkg::ACTIVE_LO];
	assign trailNow = trailCount(req_q.write,
		timing_q[smbc_pkg::TRAIL_HI:smbc_pkg::TRAIL_LO],
		wbufCtrl_q[smbc_pkg::OVERRIDE_BIT]);

	// classify a request offered while the sequencer is idle
	assign idleReq     = cpuReqValid && state_q == smbc_pkg::ST_IDLE;
	assign faultReq    = idleReq && cpuReq.periph && guard_q[cpuReq.psel] && !cpuPriv; // RL14
	assign internalReq = idleReq && !faultReq && cpuReq.periph
		&& !placement_q[cpuReq.psel]; // RL13
	assign startExt    = idleReq && !faultReq && !internalReq;
	assign bufferedReq = startExt && cpuReq.write && (cpuReq.periph
		? pbufCtrl_q[smbc_pkg::BUF_ON_BIT] // RL12
		: wbufCtrl_q[smbc_pkg::BUF_ON_BIT]); // RL10
	assign finish = (state_q == smbc_pkg::ST_ACTIVE && cnt_q == 4'h0 && trailNow == 4'h0)
		|| (state_q == smbc_pkg::ST_TRAIL && cnt_q == 4'h0);

	// processor handshake; a busy buffered write stalls new requests
	assign cpuReady = faultReq || internalReq || bufferedReq || (finish && owner_q); // RL10 RL11
	assign cpuFault = faultReq;
	assign intPeriphStrobe = internalReq;

	// next state and cycle count
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			smbc_pkg::ST_IDLE: begin
				if (startExt && cpuReq.write && leadF != 2'h0) begin
					state_d = smbc_pkg::ST_WRITE_STROBE_DELAY; // RL4
					cnt_d   = {2'h0, leadF - 2'h1};
				end else if (startExt) begin
					state_d = smbc_pkg::ST_ACTIVE;
					cnt_d   = activeF; // RL6
				end
			end
			smbc_pkg::ST_WRITE_STROBE_DELAY: begin
				if (cnt_q == 4'h0) begin
					state_d = smbc_pkg::ST_ACTIVE;
					cnt_d   = activeF; // RL6
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			smbc_pkg::ST_ACTIVE: begin
				if (cnt_q != 4'h0) begin
					cnt_d = cnt_q - 4'h1;
				end else if (trailNow != 4'h0) begin
					state_d = smbc_pkg::ST_TRAIL; // RL5 RL9
					cnt_d   = trailNow - 4'h1;
				end else begin
					state_d = smbc_pkg::ST_IDLE;
				end
			end
			smbc_pkg::ST_TRAIL: begin
				if (cnt_q == 4'h0) begin
					state_d = smbc_pkg::ST_IDLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= smbc_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// request capture in the first cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			req_q   <= '0;
			owner_q <= 1'b0;
		end else if (startExt) begin
			req_q   <= cpuReq; // RL10 RL12
			owner_q <= !bufferedReq;
		end
	end

	// read data captured at the end of the active phase
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cpuRdata_q <= 32'h0000_0000;
		end else if (state_q == smbc_pkg::ST_ACTIVE && cnt_q == 4'h0 && !req_q.write) begin
			cpuRdata_q <= extRdata;
		end
	end

	// external bus drive
	assign cpuRdata       = cpuRdata_q;
	assign extSel         = state_q != smbc_pkg::ST_IDLE;
	assign extWriteStrobe = state_q == smbc_pkg::ST_ACTIVE && req_q.write; // RL4
	assign extReadStrobe  = state_q == smbc_pkg::ST_ACTIVE && !req_q.write;
	assign extAddr        = req_q.addr;
	assign extWdata       = req_q.wdata;
	assign extWidth       = timing_q[smbc_pkg::WIDTH_HI:smbc_pkg::WIDTH_LO]; // RL8
	assign periphExternal = req_q.periph && placement_q[req_q.psel]; // RL13

	// checks
	AST_PRIV_WRITE: assert property (@(posedge clk_sys) disable iff (reset) // RL2
		regSel && regWrite && !privMode |=> $stable(timing_q) && $stable(guard_q))
		else $error("unprivileged write changed a register");
	AST_SIZE_WRITE: assert property (@(posedge clk_sys) disable iff (reset) // RL16
		regSel && regWrite && regSize != smbc_pkg::SIZE_HALF
		|=> $stable(placement_q) && $stable(wbufCtrl_q) && $stable(timing_q))
		else $error("non half-word write changed a register");
	AST_LOW_LANES: assert property (@(posedge clk_sys) disable iff (reset) // RL3
		regSel && !regWrite |=> regRdata[31:16] == 16'h0000)
		else $error("register data outside low lanes");
	AST_WRITE_STROBE_DELAY_TWO: assert property (@(posedge clk_sys) disable iff (reset) // RL4
		startExt && cpuReq.write && leadF == 2'h2
		|=> !extWriteStrobe [*2] ##1 extWriteStrobe)
		else $error("write strobe write_strobe_delay wrong");
	AST_ACTIVE_THREE: assert property (@(posedge clk_sys) disable iff (reset) // RL6
		$rose(extReadStrobe) && activeF == 4'h3 |-> extReadStrobe [*4] ##1 !extReadStrobe)
		else $error("active wait count wrong");
	AST_TRAIL_THREE: assert property (@(posedge clk_sys) disable iff (reset) // RL5
		$fell(extReadStrobe) && timing_q[smbc_pkg::TRAIL_HI:smbc_pkg::TRAIL_LO] == 3'h3
		|-> extSel [*3] ##1 !extSel)
		else $error("trailing wait count wrong");
	AST_TRAIL_MIN: assert property (@(posedge clk_sys) disable iff (reset) // RL9
		$fell(extWriteStrobe) && !wbufCtrl_q[smbc_pkg::OVERRIDE_BIT] |-> extSel)
		else $error("missing forced trailing write wait");
	AST_BUF_RELEASE: assert property (@(posedge clk_sys) disable iff (reset) // RL10
		startExt && cpuReq.write && !cpuReq.periph && wbufCtrl_q[smbc_pkg::BUF_ON_BIT]
		|-> cpuReady ##1 extSel)
		else $error("buffered write did not release processor");
	AST_BUF_STALL: assert property (@(posedge clk_sys) disable iff (reset) // RL11
		cpuReqValid && extSel && !owner_q |-> !cpuReady)
		else $error("request not stalled behind buffered write");
	AST_GUARD: assert property (@(posedge clk_sys) disable iff (reset) // RL14
		idleReq && cpuReq.periph && guard_q[cpuReq.psel] && !cpuPriv
		|-> cpuFault ##1 !extSel)
		else $error("guarded peripheral reached outside privilege");
	AST_RESET_ZERO: assert property (@(posedge clk_sys) // RL15
		reset |=> timing_q == smbc_pkg::REG_RESET && pbufCtrl_q == smbc_pkg::REG_RESET)
		else $error("fields not zero after reset");
	AST_RESET_ALL: assert property (@(posedge clk_sys) // RL15
		reset |=> wbufCtrl_q == smbc_pkg::REG_RESET && placement_q == smbc_pkg::REG_RESET
		&& guard_q == smbc_pkg::REG_RESET && !extSel)
		else $error("buffer, placement or guard not zero after reset");

	// register port checks
	AST_ENDIAN_READ: assert property (@(posedge clk_sys) disable iff (reset) // RL7
		regSel && !regWrite && regAddr == smbc_pkg::OFF_TIMING
		|=> regRdata[smbc_pkg::ENDIAN_BIT] == $past(endianSync_q))
		else $error("byte order bit not reported");
	AST_WIDTH_FIELD: assert property (@(posedge clk_sys) disable iff (reset) // RL8
		regWrOk && regAddr == smbc_pkg::OFF_TIMING
		|=> extWidth == $past(regWdata[smbc_pkg::WIDTH_HI:smbc_pkg::WIDTH_LO]))
		else $error("width field not applied");

	// sequencer checks
	AST_PBUF_RELEASE: assert property (@(posedge clk_sys) disable iff (reset) // RL12
		startExt && cpuReq.write && cpuReq.periph && pbufCtrl_q[smbc_pkg::BUF_ON_BIT]
		|-> cpuReady ##1 extSel)
		else $error("buffered peripheral write did not release processor");
	AST_PLACE_EXT: assert property (@(posedge clk_sys) disable iff (reset) // RL13
		startExt && cpuReq.periph |=> periphExternal)
		else $error("external peripheral not marked external");
	AST_INTERNAL_LOCAL: assert property (@(posedge clk_sys) disable iff (reset) // RL13
		internalReq |-> cpuReady && !cpuFault ##1 !extSel)
		else $error("internal peripheral went to the external bus");
	AST_WRITE_NO_WRITE_STROBE_DELAY: assert property (@(posedge clk_sys) disable iff (reset) // RL4
		startExt && cpuReq.write && leadF == 2'h0 |=> extWriteStrobe)
		else $error("write strobe delayed without write_strobe_delay");
	AST_READ_NO_WRITE_STROBE_DELAY: assert property (@(posedge clk_sys) disable iff (reset) // RL4
		startExt && !cpuReq.write |=> extReadStrobe)
		else $error("read strobe delayed");

	COV_BUFFERED: cover property (@(posedge clk_sys) disable iff (reset)
		bufferedReq ##1 cpuReqValid && !cpuReady);
	COV_WRITE_STROBE_DELAY_WRITE: cover property (@(posedge clk_sys) disable iff (reset)
		$rose(extWriteStrobe) && leadF == 2'h3);
	COV_FAULT: cover property (@(posedge clk_sys) disable iff (reset) cpuFault);
	COV_TRAIL_READ: cover property (@(posedge clk_sys) disable iff (reset)
		$fell(extReadStrobe) ##1 extSel);
	COV_INTERNAL: cover property (@(posedge clk_sys) disable iff (reset) intPeriphStrobe);

endmodule : smbc_controller

// file: smbc_mem_model.sv
// static memory model standing on the external side of the controller
// assumes strobes and address come registered from the controller
`timescale 1ns/1ns
module smbc_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        extReadStrobe,
	input  wire logic        extWriteStrobe,
	input  wire logic [31:0] extAddr,
	input  wire logic [31:0] extWdata,
	output logic      [31:0] extRdata
);
	logic [31:0] mem [16];
	logic [31:0] last = 32'h0000_0000;
	// store on write strobe, remember the last value read out
	always_ff @(posedge clk_sys) begin
		if (extWriteStrobe) mem[extAddr[5:2]] <= extWdata;
		if (extReadStrobe) last <= mem[extAddr[5:2]];
	end
	// data only while read strobed, inverted stale value otherwise
	assign extRdata = extReadStrobe ? mem[extAddr[5:2]] : ~last;
endmodule : smbc_mem_model

// file: smbc_pkg.sv
// constants, types and register map of the static memory bus controller
// assumes one 25 MHz processor bus clock and a synchronous active-high reset
package smbc_pkg;

	// register byte addresses on the processor bus
	localparam int unsigned ADDR_W            = 40;
	localparam logic [39:0] OFF_TIMING        = 40'hFF_FFFF_FD00;
	localparam logic [39:0] OFF_WBUF_CTRL     = 40'hFF_FFFF_FD2C;
	localparam logic [39:0] OFF_PBUF_CTRL     = 40'hFF_FFFF_FD30;
	localparam logic [39:0] OFF_PLACEMENT     = 40'hFF_FFFF_FD34;
	localparam logic [39:0] OFF_PRIV_GUARD    = 40'hFF_FFFF_FD38;

	// field positions of static_memory_timing
	localparam int unsigned WRITE_STROBE_DELAY_HI           = 13;
	localparam int unsigned WRITE_STROBE_DELAY_LO           = 12;
	localparam int unsigned TRAIL_HI          = 11;
	localparam int unsigned TRAIL_LO          = 9;
	localparam int unsigned ACTIVE_HI         = 7;
	localparam int unsigned ACTIVE_LO         = 4;
	localparam int unsigned ENDIAN_BIT        = 3;
	localparam int unsigned WIDTH_HI          = 1;
	localparam int unsigned WIDTH_LO          = 0;
	// field positions of the buffer control registers
	localparam int unsigned OVERRIDE_BIT      = 1;
	localparam int unsigned BUF_ON_BIT        = 0;

	// writable bits; reserved bits read as zero, the read-only byte order bit reads the synchronised strap
	localparam logic [15:0] TIMING_WMASK      = 16'h3EF3;
	localparam logic [15:0] WBUF_WMASK        = 16'h0003;
	localparam logic [15:0] PBUF_WMASK        = 16'h0001;
	localparam logic [15:0] REG_RESET         = 16'h0000;
	localparam logic [15:0] READ_PAD          = 16'h0000;

	// access size code on the register port
	localparam logic [1:0]  SIZE_HALF         = 2'h1;

	// access sequencer states, gray along idle-write_strobe_delay-active-trail
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_WRITE_STROBE_DELAY   = 2'h1,
		ST_ACTIVE = 2'h3,
		ST_TRAIL  = 2'h2
	} smbc_state_type;

	// one processor request to memory or an expansion peripheral
	typedef struct packed {
		logic        write;
		logic        periph;
		logic [3:0]  psel;
		logic [31:0] addr;
		logic [31:0] wdata;
	} smbc_req_type;

endpackage : smbc_pkg

// file: static_memory_bus_controller_tb.sv
// testbench of the static memory bus controller: register port and access timing
// assumes smbc_pkg and smbc_mem_model are compiled first
`timescale 1ns/1ns
module static_memory_bus_controller_tb;
	logic                   clk_sys = 0;
	logic                   reset = 1;
	logic                   regSel = 0, regWrite = 0, privMode = 0;
	logic                   cpuReqValid = 0, cpuPriv = 0;
	logic [1:0]             regSize = 2'h0, extWidth;
	logic [39:0]            regAddr = 40'h00_0000_0000;
	logic [31:0]            regWdata = 32'h0000_0000;
	logic [31:0]            regRdata, cpuRdata, extRdata, extAddr, extWdata;
	smbc_pkg::smbc_req_type cpuReq = '0;
	logic                   cpuReady, cpuFault, extSel, extWriteStrobe, extReadStrobe;
	logic                   periphExternal, intPeriphStrobe, fl, st, pe;
	int                     num_errors = 0, n_checks = 0, n;

	// free-running bus clock
	initial forever #20 clk_sys = ~clk_sys;

	smbc_controller i_smbc_controller (.clk_sys(clk_sys), .reset(reset), .regSel(regSel),
		.regWrite(regWrite), .regSize(regSize), .regAddr(regAddr), .regWdata(regWdata),
		.privMode(privMode), .regRdata(regRdata), .endianPin(1'b1),
		.cpuReqValid(cpuReqValid), .cpuReq(cpuReq), .cpuPriv(cpuPriv), .cpuReady(cpuReady),
		.cpuFault(cpuFault), .cpuRdata(cpuRdata), .extRdata(extRdata), .extSel(extSel),
		.extWriteStrobe(extWriteStrobe), .extReadStrobe(extReadStrobe), .extAddr(extAddr),
		.extWdata(extWdata), .extWidth(extWidth), .periphExternal(periphExternal),
		.intPeriphStrobe(intPeriphStrobe));

	smbc_mem_model i_smbc_mem_model (.clk_sys(clk_sys), .extReadStrobe(extReadStrobe),
		.extWriteStrobe(extWriteStrobe), .extAddr(extAddr), .extWdata(extWdata),
		.extRdata(extRdata));

	// summary line, verdict, end of run
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// compare one value
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one register write cycle
	task automatic reg_wr(logic [39:0] a, logic [15:0] d, logic p = 1,
		logic [1:0] s = smbc_pkg::SIZE_HALF);
		@(negedge clk_sys);
		{regSel, regWrite, regAddr, regWdata, privMode, regSize} = {2'b11, a, 16'h0000, d, p, s};
		@(negedge clk_sys);
		regSel = 0;
	endtask : reg_wr

	// one register read cycle, data checked a cycle later
	task automatic reg_rd(logic [39:0] a, logic [15:0] e);
		@(negedge clk_sys);
		{regSel, regWrite, regAddr} = {2'b10, a};
		@(negedge clk_sys);
		regSel = 0;
		chk("regRdata", {16'h0000, e}, regRdata);
	endtask : reg_rd

	// one memory request held until accepted; n counts cycles after the start cycle
	task automatic mem(logic w, logic p, logic [3:0] ps, logic [31:0] a, logic [31:0] d,
		logic pv, logic hold);
		@(negedge clk_sys);
		cpuReq = '{w, p, ps, a, d};
		cpuPriv = pv;
		cpuReqValid = 1;
		n = 0;
		#1;
		while (cpuReady !== 1'b1) begin
			@(negedge clk_sys);
			#1;
			n++;
			if (n > 200) begin
				num_errors++;
				give_verdict();
			end
		end
		{fl, st} = {cpuFault, intPeriphStrobe};
		@(posedge clk_sys);
		#1;
		pe = periphExternal;
		if (!hold) begin
			@(negedge clk_sys);
			cpuReqValid = 0;
		end
	endtask : mem

	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 0;
		repeat (2) @(negedge clk_sys);
		reg_rd(smbc_pkg::OFF_TIMING, 16'h0008);
		reg_rd(smbc_pkg::OFF_WBUF_CTRL, 16'h0000);
		reg_rd(smbc_pkg::OFF_PBUF_CTRL, 16'h0000);
		reg_rd(smbc_pkg::OFF_PLACEMENT, 16'h0000);
		reg_rd(smbc_pkg::OFF_PRIV_GUARD, 16'h0000);
		reg_rd(40'hFF_FFFF_FD04, 16'h0000);
		reg_wr(smbc_pkg::OFF_TIMING, 16'h2012, 0);
		reg_rd(smbc_pkg::OFF_TIMING, 16'h0008);
		reg_wr(smbc_pkg::OFF_TIMING, 16'hFFFF, 1, 2'h2);
		reg_rd(smbc_pkg::OFF_TIMING, 16'h0008);
		reg_wr(smbc_pkg::OFF_TIMING, 16'hFFFF);
		reg_rd(smbc_pkg::OFF_TIMING, 16'h3EFB);
		reg_wr(smbc_pkg::OFF_TIMING, 16'h2012);
		reg_rd(smbc_pkg::OFF_TIMING, 16'h201A);
		chk("extWidth", 32'h0000_0002, extWidth);
		// unbuffered write: write_strobe_delay 2, strobe 1+1, one forced trailing wait
		mem(1, 0, 4'h0, 32'h0000_0010, 32'hCAFE_1234, 1, 0);
		chk("write cycles", 32'h0000_0005, n);
		mem(0, 0, 4'h0, 32'h0000_0010, 32'h0000_0000, 1, 0);
		chk("read cycles", 32'h0000_0002, n);
		chk("cpuRdata", 32'hCAFE_1234, cpuRdata);
		reg_wr(smbc_pkg::OFF_WBUF_CTRL, 16'hFFFF);
		reg_rd(smbc_pkg::OFF_WBUF_CTRL, 16'h0003);
		// buffered write released at once, next request stalled behind it
		mem(1, 0, 4'h0, 32'h0000_0014, 32'h5A5A_0F0F, 1, 1);
		chk("buffered cycles", 32'h0000_0000, n);
		mem(0, 0, 4'h0, 32'h0000_0014, 32'h0000_0000, 1, 0);
		chk("stalled", 32'h0000_0001, n > 3);
		chk("cpuRdata", 32'h5A5A_0F0F, cpuRdata);
		reg_wr(smbc_pkg::OFF_TIMING, 16'h0631);
		reg_rd(smbc_pkg::OFF_TIMING, 16'h0639);
		chk("extWidth", 32'h0000_0001, extWidth);
		// read with three active and three trailing waits
		mem(0, 0, 4'h0, 32'h0000_0010, 32'h0000_0000, 1, 0);
		chk("long read cycles", 32'h0000_0007, n);
		chk("cpuRdata", 32'hCAFE_1234, cpuRdata);
		reg_wr(smbc_pkg::OFF_PBUF_CTRL, 16'hFFFF);
		reg_rd(smbc_pkg::OFF_PBUF_CTRL, 16'h0001);
		reg_wr(smbc_pkg::OFF_PLACEMENT, 16'hA5A5);
		reg_rd(smbc_pkg::OFF_PLACEMENT, 16'hA5A5);
		reg_wr(smbc_pkg::OFF_PRIV_GUARD, 16'hA5A5);
		reg_rd(smbc_pkg::OFF_PRIV_GUARD, 16'hA5A5);
		reg_wr(smbc_pkg::OFF_WBUF_CTRL, 16'h0002);
		// external peripheral write buffered by the peripheral enable alone
		mem(1, 1, 4'h5, 32'h0000_0018, 32'h1111_2222, 1, 0);
		chk("periph buffered", 32'h0000_0000, n);
		chk("periphExternal", 32'h0000_0001, pe);
		mem(0, 1, 4'h0, 32'h0000_0000, 32'h0000_0000, 0, 0);
		chk("cpuFault", 32'h0000_0001, fl);
		mem(0, 1, 4'h3, 32'h0000_0000, 32'h0000_0000, 0, 0);
		chk("intPeriphStrobe", 32'h0000_0001, st);
		chk("no fault", 32'h0000_0000, fl);
		give_verdict();
	end
endmodule : static_memory_bus_controller_tb
